// ### core/t01_timer_ctrl.sv
// timer 0/1 control: control register, external interrupt flags, counters
// assumes the core issues byte and bit accesses one cycle wide on clk_sys_i
`timescale 1ns/1ps
`include "t01_defines.svh"

// Summary of operation
// - timer 0 mode 3 splits it into two independent 8-bit counters
// - low byte uses timer 0 run, counter select, gate and overflow flag
// - low byte counts system or prescaled clock, or external input per counter select
// - high byte is timer only, on system or prescaled clock
// - high byte runs only while timer 1 run bit is set
// - high byte overflow sets timer 1 overflow flag and its interrupt
// - in split, timer 1 modes 0-2 run internal-only, never set flag
// - in split, timer 1 overflow pulse still feeds baud and conversion
// - in split, timer 1 runs in modes 0-2 and stops in mode 3
// - bit 7 timer 1 flag: hardware set, software clear, vector clear
// - bit 5 timer 0 flag: hardware set, software clear, vector clear
// - bit 6 runs timer 1 (timer 0 high byte in split), bit 4 runs timer 0; zero stops them
// - bit 3 ext irq 1 flag; vector clears it only in edge mode
// - bit 1 ext irq 0 flag; vector clears it only in edge mode
// - bit 2 picks ext irq 1 level or edge; polarity set elsewhere
// - bit 0 picks ext irq 0 level or edge; polarity set elsewhere
// - control register at 0x88, bit addressable, resets to zero
module t01_timer_ctrl (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic       sfr_rd_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_bit_wr_i,
	input  wire logic [7:0] sfr_bit_addr_i,
	input  wire logic       sfr_bit_val_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            sfr_hit_o,
	input  wire logic [1:0] timer_zero_mode_i,
	input  wire logic [1:0] timer_one_mode_i,
	input  wire logic       timer_zero_counter_select_i,
	input  wire logic       timer_one_counter_select_i,
	input  wire logic       timer_zero_gate_i,
	input  wire logic       timer_one_gate_i,
	input  wire logic       timer_zero_prescale_sel_i,
	input  wire logic       timer_one_prescale_sel_i,
	input  wire logic       prescale_tick_i,
	input  wire logic       ext_irq_zero_polarity_i,
	input  wire logic       ext_irq_one_polarity_i,
	input  wire logic       ext_irq_zero_input_i,
	input  wire logic       ext_irq_one_input_i,
	input  wire logic       timer_zero_count_pin_i,
	input  wire logic       timer_one_count_pin_i,
	input  wire logic       vector_t0_i,
	input  wire logic       vector_t1_i,
	input  wire logic       vector_irq0_i,
	input  wire logic       vector_irq1_i,
	output logic            irq_t0_o,
	output logic            irq_t1_o,
	output logic            irq_ext0_o,
	output logic            irq_ext1_o,
	output logic            timer_one_ovf_pulse_o,
	output logic      [7:0] timer_zero_low_byte_o,
	output logic      [7:0] timer_zero_high_byte_o,
	output logic      [7:0] timer_one_low_byte_o,
	output logic      [7:0] timer_one_high_byte_o
);
	localparam int NPIN = 4;

	// pin synchroniser: order is irq0, irq1, t0 count, t1 count
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] meta_q;
	logic [NPIN-1:0] meta_d;
	logic [NPIN-1:0] sync_q;
	logic [NPIN-1:0] sync_d;
	logic [NPIN-1:0] prev_q;
	logic [NPIN-1:0] prev_d;

	assign pins = {timer_one_count_pin_i, timer_zero_count_pin_i,
		ext_irq_one_input_i, ext_irq_zero_input_i};

	always_comb begin
		meta_d = pins;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// no reset: the flops follow the pins through reset, so an idle active-low
	// line is not taken for a level or an edge when reset lifts
	always_ff @(posedge clk_sys_i) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
		prev_q <= prev_d;
	end

	// interrupt inputs made active high by their polarity settings
	logic irq0_act;
	logic irq1_act;
	logic irq0_act_prev;
	logic irq1_act_prev;
	logic irq0_edge;
	logic irq1_edge;
	logic t0_pin_fall;
	logic t1_pin_fall;

	assign irq0_act      = ~(sync_q[0] ^ ext_irq_zero_polarity_i);
	assign irq1_act      = ~(sync_q[1] ^ ext_irq_one_polarity_i);
	assign irq0_act_prev = ~(prev_q[0] ^ ext_irq_zero_polarity_i);
	assign irq1_act_prev = ~(prev_q[1] ^ ext_irq_one_polarity_i);
	assign irq0_edge     = irq0_act & ~irq0_act_prev;
	assign irq1_edge     = irq1_act & ~irq1_act_prev;
	// external count inputs step on the falling edge
	assign t0_pin_fall   = prev_q[2] & ~sync_q[2];
	assign t1_pin_fall   = prev_q[3] & ~sync_q[3];

	// control register
	t01_pkg::t01_ctrl_t ctrl_q;
	t01_pkg::t01_ctrl_t ctrl_d;
	logic               byte_wr;
	logic               bit_wr;
	logic [2:0]         bit_sel;
	logic               t0_ovf_set;
	logic               t1_ovf_set;
	logic               irq0_set;
	logic               irq1_set;

	assign byte_wr = sfr_wr_i & (sfr_addr_i == `T01_CTRL_ADDR);
	assign bit_wr  = sfr_bit_wr_i & (sfr_bit_addr_i[7:3] == `T01_BITADDR_BASE);
	assign bit_sel = sfr_bit_addr_i[2:0];

	// level mode sets while the line is active, edge mode on the edge
	assign irq0_set = ctrl_q.irq0_type ? irq0_edge : irq0_act;
	assign irq1_set = ctrl_q.irq1_type ? irq1_edge : irq1_act;

	always_comb begin
		logic [7:0] v;
		v = ctrl_q;
		if (byte_wr) begin
			v = sfr_wdata_i;
		end else if (bit_wr) begin
			v[bit_sel] = sfr_bit_val_i;
		end
		ctrl_d = v;
		// vectoring clears the flag (ext irq flags in edge mode only); a same-cycle hardware set still wins
		if (vector_t1_i) begin
			ctrl_d.t1_ovf = 1'b0;
		end
		if (vector_t0_i) begin
			ctrl_d.t0_ovf = 1'b0;
		end
		if (vector_irq1_i && ctrl_q.irq1_type) begin
			ctrl_d.irq1_flag = 1'b0;
		end
		if (vector_irq0_i && ctrl_q.irq0_type) begin
			ctrl_d.irq0_flag = 1'b0;
		end
		if (t1_ovf_set) begin
			ctrl_d.t1_ovf = 1'b1;
		end
		if (t0_ovf_set) begin
			ctrl_d.t0_ovf = 1'b1;
		end
		if (irq1_set) begin
			ctrl_d.irq1_flag = 1'b1;
		end
		if (irq0_set) begin
			ctrl_d.irq0_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_q <= `T01_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// read port: data registered, one cycle after the read strobe
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       hit_q;
	logic       hit_d;

	always_comb begin
		hit_d   = sfr_rd_i & (sfr_addr_i == `T01_CTRL_ADDR);
		rdata_d = hit_d ? ctrl_q : `T01_ZERO_BYTE;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rdata_q <= `T01_ZERO_BYTE;
			hit_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
		end
	end

	assign sfr_rdata_o = rdata_q;
	assign sfr_hit_o   = hit_q;

	// counter stages
	t01_cnt_if cnt_if [`T01_NUM_BYTES] ();

	genvar g;
	generate
		for (g = 0; g < `T01_NUM_BYTES; g++) begin : g_byte
			t01_byte_cnt u_cnt (
				.clk_sys_i (clk_sys_i),
				.rst_i     (rst_i),
				.port      (cnt_if[g])
			);
		end
	endgenerate

	logic split0;
	logic t0_base;
	logic t1_base;
	logic t0_gate_ok;
	logic t1_gate_ok;
	logic t0_run;
	logic t1_run;
	logic t0_low_src;
	logic t1_low_src;
	logic t1_ovf;

	assign split0  = (timer_zero_mode_i == `T01_MODE_SPLIT);
	assign t0_base = timer_zero_prescale_sel_i ? prescale_tick_i : 1'b1;
	assign t1_base = timer_one_prescale_sel_i ? prescale_tick_i : 1'b1;

	// gate lets the external interrupt line hold the timer off
	assign t0_gate_ok = ~timer_zero_gate_i | irq0_act;
	assign t1_gate_ok = ~timer_one_gate_i | irq1_act;
	assign t0_run     = ctrl_q.t0_run & t0_gate_ok;

	// in split, timer 1 run bit belongs to the high byte of timer 0
	always_comb begin
		if (split0) begin
			t1_run = (timer_one_mode_i != `T01_MODE_SPLIT);
		end else begin
			t1_run = ctrl_q.t1_run & t1_gate_ok &
				(timer_one_mode_i != `T01_MODE_SPLIT);
		end
	end

	assign t0_low_src = timer_zero_counter_select_i ? t0_pin_fall : t0_base;
	// split forbids external clocking of timer 1
	assign t1_low_src = (timer_one_counter_select_i && !split0) ?
		t1_pin_fall : t1_base;

	// timer 0 stages
	assign cnt_if[`T01_IDX_T0_LOW].tick = t0_run & t0_low_src;
	assign cnt_if[`T01_IDX_T0_LOW].top =
		(timer_zero_mode_i == `T01_MODE_13BIT) ? `T01_TOP_13BIT : `T01_TOP_FULL;
	assign cnt_if[`T01_IDX_T0_LOW].reload =
		(timer_zero_mode_i == `T01_MODE_RELOAD) ? cnt_if[`T01_IDX_T0_HIGH].count
		: `T01_ZERO_BYTE;

	always_comb begin
		case (timer_zero_mode_i)
			`T01_MODE_SPLIT: begin
				// high byte: internal clock only, run by timer 1 run bit
				cnt_if[`T01_IDX_T0_HIGH].tick = ctrl_q.t1_run & t0_base;
			end
			`T01_MODE_RELOAD: begin
				cnt_if[`T01_IDX_T0_HIGH].tick = 1'b0;
			end
			default: begin
				cnt_if[`T01_IDX_T0_HIGH].tick = cnt_if[`T01_IDX_T0_LOW].wrap;
			end
		endcase
	end

	assign cnt_if[`T01_IDX_T0_HIGH].top    = `T01_TOP_FULL;
	assign cnt_if[`T01_IDX_T0_HIGH].reload = `T01_ZERO_BYTE;

	// timer 1 stages
	assign cnt_if[`T01_IDX_T1_LOW].tick = t1_run & t1_low_src;
	assign cnt_if[`T01_IDX_T1_LOW].top =
		(timer_one_mode_i == `T01_MODE_13BIT) ? `T01_TOP_13BIT : `T01_TOP_FULL;
	assign cnt_if[`T01_IDX_T1_LOW].reload =
		(timer_one_mode_i == `T01_MODE_RELOAD) ? cnt_if[`T01_IDX_T1_HIGH].count
		: `T01_ZERO_BYTE;
	assign cnt_if[`T01_IDX_T1_HIGH].tick =
		(timer_one_mode_i != `T01_MODE_RELOAD) & cnt_if[`T01_IDX_T1_LOW].wrap;
	assign cnt_if[`T01_IDX_T1_HIGH].top    = `T01_TOP_FULL;
	assign cnt_if[`T01_IDX_T1_HIGH].reload = `T01_ZERO_BYTE;

	assign t1_ovf = (timer_one_mode_i == `T01_MODE_RELOAD) ?
		cnt_if[`T01_IDX_T1_LOW].wrap : cnt_if[`T01_IDX_T1_HIGH].wrap;

	// overflow flag sources
	always_comb begin
		if (split0) begin
			t0_ovf_set = cnt_if[`T01_IDX_T0_LOW].wrap;
			t1_ovf_set = cnt_if[`T01_IDX_T0_HIGH].wrap;
		end else begin
			t0_ovf_set = (timer_zero_mode_i == `T01_MODE_RELOAD) ?
				cnt_if[`T01_IDX_T0_LOW].wrap : cnt_if[`T01_IDX_T0_HIGH].wrap;
			t1_ovf_set = t1_ovf;
		end
	end

	// baud/conversion pulse comes from timer 1 even when split
	logic ovf_pulse_q;
	logic ovf_pulse_d;

	always_comb begin
		ovf_pulse_d = t1_ovf;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ovf_pulse_q <= 1'b0;
		end else begin
			ovf_pulse_q <= ovf_pulse_d;
		end
	end

	assign timer_one_ovf_pulse_o = ovf_pulse_q;

	// interrupt requests are the flags themselves
	assign irq_t0_o   = ctrl_q.t0_ovf;
	assign irq_t1_o   = ctrl_q.t1_ovf;
	assign irq_ext0_o = ctrl_q.irq0_flag;
	assign irq_ext1_o = ctrl_q.irq1_flag;

	assign timer_zero_low_byte_o  = cnt_if[`T01_IDX_T0_LOW].count;
	assign timer_zero_high_byte_o = cnt_if[`T01_IDX_T0_HIGH].count;
	assign timer_one_low_byte_o   = cnt_if[`T01_IDX_T1_LOW].count;
	assign timer_one_high_byte_o  = cnt_if[`T01_IDX_T1_HIGH].count;
endmodule // t01_timer_ctrl

// ### core/t01_defines.svh
// constants for the timer 0/1 control block: offsets, bit positions, codes
// assumes inclusion by bare name from the package and the core modules
`ifndef T01_DEFINES_SVH
`define T01_DEFINES_SVH

`define T01_CTRL_ADDR      8'h88
`define T01_CTRL_RESET     8'h00
`define T01_BITADDR_BASE   5'h11

`define T01_BIT_T1_OVF     3'h7
`define T01_BIT_T1_RUN     3'h6
`define T01_BIT_T0_OVF     3'h5
`define T01_BIT_T0_RUN     3'h4
`define T01_BIT_IRQ1_FLAG  3'h3
`define T01_BIT_IRQ1_TYPE  3'h2
`define T01_BIT_IRQ0_FLAG  3'h1
`define T01_BIT_IRQ0_TYPE  3'h0

`define T01_MODE_13BIT     2'h0
`define T01_MODE_16BIT     2'h1
`define T01_MODE_RELOAD    2'h2
`define T01_MODE_SPLIT     2'h3

`define T01_TOP_FULL       8'hFF
`define T01_TOP_13BIT      8'h1F
`define T01_ZERO_BYTE      8'h00

`define T01_NUM_BYTES      4
`define T01_IDX_T0_LOW     0
`define T01_IDX_T0_HIGH    1
`define T01_IDX_T1_LOW     2
`define T01_IDX_T1_HIGH    3

`endif

// ### core/t01_pkg.sv
// types shared by the timer 0/1 control block
// assumes t01_defines.svh is on the include path
`include "t01_defines.svh"

package t01_pkg;

	typedef struct packed {
		logic t1_ovf;
		logic t1_run;
		logic t0_ovf;
		logic t0_run;
		logic irq1_flag;
		logic irq1_type;
		logic irq0_flag;
		logic irq0_type;
	} t01_ctrl_t;

	typedef logic [7:0] t01_byte_t;

endpackage

// ### core/t01_cnt_if.sv
// carrier between the control logic and one 8-bit counter stage
// assumes a single system clock shared by both ends
`timescale 1ns/1ps

interface t01_cnt_if;
	logic             tick;
	t01_pkg::t01_byte_t top;
	t01_pkg::t01_byte_t reload;
	t01_pkg::t01_byte_t count;
	logic             wrap;

	modport ctl (output tick, output top, output reload, input count, input wrap);
	modport cnt (input tick, input top, input reload, output count, output wrap);
endinterface

// ### core/t01_byte_cnt.sv
// one 8-bit counter stage: counts on tick, wraps at top to the reload value
// assumes tick is a one-cycle qualifier on the system clock
`timescale 1ns/1ps
`include "t01_defines.svh"

module t01_byte_cnt (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	t01_cnt_if.cnt    port
);
	t01_pkg::t01_byte_t count_q;
	t01_pkg::t01_byte_t count_d;
	logic               at_top;

	assign at_top    = (count_q == port.top);
	assign port.wrap = port.tick & at_top;
	assign port.count = count_q;

	always_comb begin
		count_d = count_q;
		if (port.tick) begin
			count_d = at_top ? port.reload : count_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			count_q <= `T01_ZERO_BYTE;
		end else begin
			count_q <= count_d;
		end
	end
endmodule // t01_byte_cnt

// ### bench/t01_core_model.sv
// core-side partner: answers raised requests with vector pulses
// assumes levels on the system clock; lat_i sets the answer delay
`timescale 1ns/1ps
module t01_core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] irq_i,
	input  wire logic [3:0] en_i,
	input  wire logic [3:0] lat_i,
	output logic      [3:0] vec_o
);
	logic [3:0] wait_q [4];
	// a request still raised after its pulse is answered again, as a core would
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i || !en_i[i] || !irq_i[i] || vec_o[i]) begin
				wait_q[i] <= 4'h0;
				vec_o[i] <= 1'b0;
			end else if (wait_q[i] == lat_i) begin
				vec_o[i] <= 1'b1;
			end else begin
				wait_q[i] <= wait_q[i] + 4'h1;
			end
		end
	end
endmodule // t01_core_model

// ### bench/t01_checker.sv
// port checker for the timer 0/1 control block
// assumes it is bound onto t01_timer_ctrl
`timescale 1ns/1ps
module t01_checker (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_rd_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_bit_wr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	input wire logic [1:0] timer_zero_mode_i,
	input wire logic [1:0] timer_one_mode_i,
	input wire logic       vector_t0_i,
	input wire logic       vector_t1_i,
	input wire logic       irq_t0_o,
	input wire logic       irq_t1_o,
	input wire logic [7:0] timer_zero_low_byte_o,
	input wire logic [7:0] timer_zero_high_byte_o,
	input wire logic [7:0] timer_one_low_byte_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire       sp = timer_zero_mode_i == 2'h3;
	wire       sw = sfr_wr_i || sfr_bit_wr_i;
	wire [7:0] lo = timer_zero_low_byte_o;
	wire [7:0] hi = timer_zero_high_byte_o;
	a_rd_hit: assert property (sfr_rd_i && sfr_addr_i == 8'h88 |=> sfr_hit_o)
		else $error("control read gave no hit");
	a_rd_idle: assert property (!(sfr_rd_i && sfr_addr_i == 8'h88)
		|=> !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("read data without read");
	a_hi_wrap: assert property ($past(sp) && $past(hi) == 8'hFF && hi == 8'h00 |-> irq_t1_o)
		else $error("high byte wrap left flag clear");
	a_lo_wrap: assert property ($past(sp) && $past(lo) == 8'hFF && lo == 8'h00 |-> irq_t0_o)
		else $error("low byte wrap left flag clear");
	a_t1_quiet: assert property ($rose(irq_t1_o) && $past(sp) && !$past(sw)
		|-> $past(hi) == 8'hFF) else $error("timer 1 flag set without high byte wrap");
	a_t1_stop: assert property ((sp && timer_one_mode_i == 2'h3) [*2]
		|=> $stable(timer_one_low_byte_o)) else $error("timer 1 ran in stop mode");
	a_vec_t0: assert property (vector_t0_i && sp && !sw
		|=> !irq_t0_o || $past(lo) == 8'hFF && lo == 8'h00) else $error("vector kept t0 flag");
	a_vec_t1: assert property (vector_t1_i && sp && !sw
		|=> !irq_t1_o || $past(hi) == 8'hFF && hi == 8'h00) else $error("vector kept t1 flag");
	c_hi_wrap: cover property (sp && hi == 8'hFF ##1 irq_t1_o);
	c_vec_t0: cover property (vector_t0_i && irq_t0_o);
	c_hit: cover property (sfr_hit_o);
endmodule // t01_checker
bind t01_timer_ctrl t01_checker u_chk (.*);

// ### bench/timer01_split_mode_control_test.sv
// self-checking bench for the timer 0/1 control block
// assumes t01_timer_ctrl, t01_core_model and the checker are compiled first
`timescale 1ns/1ps
module timer01_split_mode_control_test;
	logic clk_sys_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, sfr_bit_wr_i = 0;
	logic sfr_bit_val_i = 0, timer_zero_gate_i = 0, timer_one_gate_i = 0, prescale_tick_i = 0;
	logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_bit_addr_i = 0, h, g;
	logic [1:0] timer_zero_mode_i = 0, timer_one_mode_i = 0, pc = 0;
	logic timer_zero_counter_select_i = 0, timer_one_counter_select_i = 0;
	logic timer_zero_prescale_sel_i = 0, timer_one_prescale_sel_i = 0;
	logic ext_irq_zero_polarity_i = 1, ext_irq_one_polarity_i = 0;
	logic ext_irq_zero_input_i = 0, ext_irq_one_input_i = 1;
	logic timer_zero_count_pin_i = 0, timer_one_count_pin_i = 0;
	logic [3:0] ven = 0, vlat = 0;
	wire vector_t0_i, vector_t1_i, vector_irq0_i, vector_irq1_i;
	logic [7:0] sfr_rdata_o, timer_zero_low_byte_o, timer_zero_high_byte_o;
	logic [7:0] timer_one_low_byte_o, timer_one_high_byte_o;
	logic sfr_hit_o, irq_t0_o, irq_t1_o, irq_ext0_o, irq_ext1_o, timer_one_ovf_pulse_o;
	int n_fail = 0, samples_checked = 0;
	t01_timer_ctrl u_dut (.*);
	t01_core_model u_core (.clk_i(clk_sys_i), .rst_i(rst_i), .en_i(ven), .lat_i(vlat),
		.irq_i({irq_ext1_o, irq_ext0_o, irq_t1_o, irq_t0_o}),
		.vec_o({vector_irq1_i, vector_irq0_i, vector_t1_i, vector_t0_i}));
	always #25 clk_sys_i = ~clk_sys_i;
	// prescaled timebase: one tick in four clocks
	always @(posedge clk_sys_i) begin
		#1 pc = pc + 2'd1;
		prescale_tick_i = pc == 2'd0;
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		sfr_addr_i = 8'h88;
		sfr_wdata_i = d;
		sfr_wr_i = 1;
		step();
		sfr_wr_i = 0;
	endtask
	task automatic bw(input logic [2:0] b, input logic v);
		sfr_bit_addr_i = 8'h88 + b;
		sfr_bit_val_i = v;
		sfr_bit_wr_i = 1;
		step();
		sfr_bit_wr_i = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr_i = a;
		sfr_rd_i = 1;
		step();
		sfr_rd_i = 0;
		chk({sfr_hit_o, sfr_rdata_o}, {a == 8'h88, e});
	endtask
	// bounded wait on the t1 flag (p=0) or the t1 overflow pulse (p=1)
	task automatic wfor(input bit p);
		repeat (300) if ((p ? timer_one_ovf_pulse_o : irq_t1_o) !== 1'b1) step();
		if ((p ? timer_one_ovf_pulse_o : irq_t1_o) !== 1'b1) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		step(6);
		rst_i = 0;
		rd(8'h88, 8'h00);
		rd(8'h89, 8'h00);
		timer_zero_mode_i = 3;
		timer_one_mode_i = 3;
		wr(8'h50);
		wfor(0);
		chk({irq_t0_o, timer_zero_high_byte_o, timer_zero_low_byte_o}, 17'h10000);
		rd(8'h88, 8'hF0);
		chk(timer_one_low_byte_o, 0);
		ven = 4'h1;
		step(3);
		chk(irq_t0_o, 0);
		ven = 0;
		bw(7, 0);
		chk(irq_t1_o, 0);
		wfor(0);
		vlat = 6;
		ven = 4'h2;
		step(4);
		chk(irq_t1_o, 1);
		step(6);
		chk(irq_t1_o, 0);
		ven = 0;
		bw(6, 0);
		h = timer_zero_high_byte_o;
		step(5);
		chk({timer_zero_high_byte_o, timer_zero_low_byte_o}, {h, h + 8'd5});
		bw(4, 0);
		h = timer_zero_low_byte_o;
		step(4);
		chk(timer_zero_low_byte_o, h);
		// pin held still: timer 1 must count from the clock anyway
		timer_one_counter_select_i = 1;
		timer_one_mode_i = 2;
		wfor(1);
		chk({timer_one_high_byte_o, timer_one_low_byte_o}, 16'h0000);
		step();
		chk(irq_t1_o, 0);
		timer_one_mode_i = 3;
		step();
		h = timer_one_low_byte_o;
		step(4);
		chk(timer_one_low_byte_o, h);
		timer_zero_counter_select_i = 1;
		bw(4, 1);
		h = timer_zero_low_byte_o;
		repeat (3) begin
			timer_zero_count_pin_i = 1;
			step(2);
			timer_zero_count_pin_i = 0;
			step(2);
		end
		step(4);
		chk(timer_zero_low_byte_o, h + 8'd3);
		timer_zero_prescale_sel_i = 1;
		bw(6, 1);
		step();
		h = timer_zero_high_byte_o;
		g = timer_zero_low_byte_o;
		// gate shut with irq 0 line idle: pin falls must not reach the low byte
		timer_zero_gate_i = 1'b1;
		repeat (5) begin
			timer_zero_count_pin_i = 1;
			step(4);
			timer_zero_count_pin_i = 0;
			step(4);
		end
		chk(timer_zero_high_byte_o, h + 8'd10);
		chk(timer_zero_low_byte_o, g);
		vlat = 0;
		bw(0, 1);
		ext_irq_zero_input_i = 1;
		step(2);
		ext_irq_zero_input_i = 0;
		step(4);
		chk(irq_ext0_o, 1);
		ven = 4'h4;
		step(3);
		chk(irq_ext0_o, 0);
		ext_irq_one_input_i = 0;
		step(5);
		chk(irq_ext1_o, 1);
		// line released first, so only a vector clear could drop the flag
		ext_irq_one_input_i = 1'b1;
		step(4);
		ven = 4'h8;
		step(3);
		chk(irq_ext1_o, 1'b1);
		ven = 4'h0;
		bw(3'h3, 1'b0);
		chk(irq_ext1_o, 1'b0);
		wr(8'h0A);
		rd(8'h88, 8'h0A);
		bw(2, 1);
		rd(8'h88, 8'h0E);
		rst_i = 1;
		step(2);
		rst_i = 0;
		chk({timer_zero_high_byte_o, timer_zero_low_byte_o}, 0);
		rd(8'h88, 8'h00);
		conclude();
	end
endmodule // timer01_split_mode_control_test
